// ==== bench/adcw_core_model.sv ====
// Behavioural model of the converter cores' power indications.
// Assumes the bench commands each core on or off and picks the pace.
module adcw_core_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Commands from the bench
    input wire logic [4:0] pwr_cmd,
    input wire logic slow,
    // Power levels towards the block
    output logic [4:0] core_pwr_on
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] dly_q;
    // A slow core reports power a few cycles late; a drop is always
    // reported at once, as a collapsing supply would be.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            core_pwr_on <= 5'h00;
            dly_q <= 2'h0;
        end else if (slow && (pwr_cmd & ~core_pwr_on) != 5'h00
                     && dly_q != 2'h3) begin
            core_pwr_on <= core_pwr_on & pwr_cmd;
            dly_q <= dly_q + 2'h1;
        end else begin
            core_pwr_on <= pwr_cmd;
            dly_q <= 2'h0;
        end
    end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the warm-up timer and ready interrupt block.
// Assumes the core model is compiled first and one 20 MHz clock.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk;
    logic rst_n;
    adcw_pkg::adcw_bus_req_s req;
    logic [15:0] rd_data;
    logic [4:0] pwr_cmd;
    logic slow;
    logic [4:0] core_pwr_on;
    logic [4:0] core_ready;
    logic irq;
    int err_total;
    int n_compared;
    int seed;
    int c;
    int cnt;
    int n;
    int eb;
    logic [15:0] rv;
    logic [15:0] ctl;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [4:0] msk;

    adcw_top #(.WARM_LIMIT(32768)) dut (.mclk(mclk), .rst_n(rst_n),
        .bus_req(req), .rd_data(rd_data), .core_pwr_on(core_pwr_on),
        .core_ready(core_ready), .irq(irq));
    adcw_core_model cores (.mclk(mclk), .rst_n(rst_n), .pwr_cmd(pwr_cmd),
        .slow(slow), .core_pwr_on(core_pwr_on));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.wdata <= d;
        req.we <= 1'b1;
        @(posedge mclk);
        req.we <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        req.addr <= a;
        req.re <= 1'b1;
        @(posedge mclk);
        req.re <= 1'b0;
        #1;
        d = rd_data;
    endtask

    function automatic int wait_len(input logic [3:0] code);
        return (code[3:2] == 2'b00) ? 16 : (1 << code);
    endfunction

    // Counts edges from the power level rising to the ready level rising;
    // the count includes the block's input synchroniser.
    task automatic warm(input int k, output int m);
        @(posedge mclk);
        pwr_cmd[k] <= 1'b1;
        m = 0;
        while (core_pwr_on[k] !== 1'b1 && m < 10) begin
            @(posedge mclk);
            #1;
            m++;
        end
        m = 0;
        while (core_ready[k] !== 1'b1 && m < 40000) begin
            @(posedge mclk);
            #1;
            m++;
        end
        // Status and the interrupt settle one edge after the ready level.
        @(posedge mclk);
        #1;
    endtask

    task automatic down;
        @(posedge mclk);
        pwr_cmd <= 5'h00;
        repeat (8) @(posedge mclk);
        #1;
        chk(16'(core_ready), 16'h0000, "ready after drop");
        rd(4'h1, rv);
    endtask

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #(95000 * 50);
        err_total++;
        end_sim();
    end

    initial begin
        seed = 32'h2416;
        err_total = 0;
        n_compared = 0;
        rst_n = 1'b0;
        req = '0;
        pwr_cmd = 5'h00;
        slow = 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd(4'h0, rv);
        chk(rv, 16'h0000, "ctrl reset");
        rd(4'h2, rv);
        chk(rv, 16'h001f, "mask reset");
        for (int a = 4; a < 16; a++) begin
            rd(4'(a), rv);
            chk(rv, 16'h0000, "unmapped");
        end
        $display("reset test done");
        // Each core alone enabled must interrupt; all others enabled not.
        for (int k = 0; k < 5; k++) begin
            eb = (k == 4) ? 7 : k;
            wr(4'h0, 16'h0001 << eb);
            warm(k, cnt);
            chk(16'(irq), 16'h0001, "irq enabled");
            down();
            wr(4'h0, 16'h008f & ~(16'h0001 << eb));
            warm(k, cnt);
            chk(16'(irq), 16'h0000, "irq gated");
            down();
            $display("gating test core %0d done", k);
        end
        // Power dropped mid warm-up must give no event.
        wr(4'h0, 16'h068f);
        @(posedge mclk);
        pwr_cmd <= 5'h01;
        repeat (20) @(posedge mclk);
        pwr_cmd <= 5'h00;
        repeat (80) @(posedge mclk);
        rd(4'h1, rv);
        chk(rv, 16'h0000, "aborted warm-up");
        $display("abort test done");
        for (int code = 0; code < 16; code++) begin
            c = $unsigned($random(seed)) % 5;
            ctl = 16'($random(seed));
            ctl[11:8] = 4'(code);
            msk = 5'($random(seed));
            slow <= 1'($random(seed));
            wr(4'h0, ctl);
            wr(4'h2, {11'h000, msk});
            rd(4'h0, rv);
            chk(rv, ctl & 16'h0f8f, "ctrl readback");
            warm(c, cnt);
            n = wait_len(4'(code));
            lo = 16'(cnt >= n + 2);
            hi = 16'(cnt <= n + 6);
            chk(lo, 16'h0001, "early");
            chk(hi, 16'h0001, "late");
            eb = (c == 4) ? 7 : c;
            chk(16'(irq), 16'(ctl[eb] & msk[c]), "irq");
            rd(4'h3, rv);
            chk(rv, 16'h0001 << c, "ready levels");
            rd(4'h1, rv);
            chk(rv, 16'h0001 << c, "status");
            rd(4'h1, rv);
            chk(rv, 16'h0000, "status cleared");
            chk(16'(irq), 16'h0000, "irq cleared");
            down();
            $display("code test %0d done", code);
        end
        end_sim();
    end
endmodule

// ==== design/adcw_sync3.sv ====
// Three-stage synchroniser for a vector of asynchronous levels.
// Assumes each input bit is a slow level from outside the clock domain.
module adcw_sync3 #(
    parameter int unsigned WIDTH = 5
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] sync_d;

    // A bit only moves once the second and third stages agree.
    always_comb begin
        sync_d = sync_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                sync_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            sync_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            sync_q <= sync_d;
        end
    end

endmodule

// ==== design/adcw_top.sv ====
// Warm-up control and ready interrupt routing for four dedicated
// converter cores and one shared core.
// Assumes the register port and the core power levels described below;
// the power levels may come from another domain and are synchronised.
module adcw_top #(
    parameter int unsigned WARM_LIMIT = adcw_pkg::WARM_CYC_MAX
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Register port
    input wire adcw_pkg::adcw_bus_req_s bus_req,
    output logic [15:0] rd_data,
    // Converter cores, index 4 is the shared core
    input wire logic [4:0] core_pwr_on,
    output logic [4:0] core_ready,
    // Interrupt
    output logic irq
);

    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [4:0] stat_q;
    logic [4:0] stat_d;
    logic [4:0] mask_q;
    logic [4:0] mask_d;
    logic [15:0] rd_q;
    logic [15:0] rd_d;
    logic irq_q;
    logic irq_d;
    logic [4:0] pwr_s;
    logic [4:0] ready_w;
    logic [4:0] evt_w;
    logic [4:0] en_w;
    logic [4:0] en_d;
    logic [3:0] code;
    logic [15:0] tbl;
    logic [15:0] wait_c;

    assign rd_data = rd_q;
    assign irq = irq_q;
    assign core_ready = ready_w;

    adcw_sync3 #(
        .WIDTH(adcw_pkg::NCORE)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(core_pwr_on),
        .sync_q(pwr_s)
    );

    // One timer per core; all share the same wait length.
    for (genvar g = 0; g < adcw_pkg::NCORE; g++) begin : g_core
        adcw_warm_cnt u_cnt (
            .mclk(mclk),
            .rst_n(rst_n),
            .pwr(pwr_s[g]),
            .wait_cyc(wait_c),
            .ready_q(ready_w[g]),
            .event_q(evt_w[g])
        );
    end

    // Warm-up code to length. WARM_LIMIT only exists to shorten long waits
    // in simulation; at its default every code keeps its full length.
    always_comb begin
        code = ctrl_q[adcw_pkg::CODE_MSB:adcw_pkg::CODE_LSB];
        case (code)
            4'hf: tbl = adcw_pkg::WARM_CYC_MIN << 11;
            4'he: tbl = adcw_pkg::WARM_CYC_MIN << 10;
            4'hd: tbl = adcw_pkg::WARM_CYC_MIN << 9;
            4'hc: tbl = adcw_pkg::WARM_CYC_MIN << 8;
            4'hb: tbl = adcw_pkg::WARM_CYC_MIN << 7;
            4'ha: tbl = adcw_pkg::WARM_CYC_MIN << 6;
            4'h9: tbl = adcw_pkg::WARM_CYC_MIN << 5;
            4'h8: tbl = adcw_pkg::WARM_CYC_MIN << 4;
            4'h7: tbl = adcw_pkg::WARM_CYC_MIN << 3;
            4'h6: tbl = adcw_pkg::WARM_CYC_MIN << 2;
            4'h5: tbl = adcw_pkg::WARM_CYC_MIN << 1;
            4'h4: tbl = adcw_pkg::WARM_CYC_MIN;
            default: tbl = adcw_pkg::WARM_CYC_MIN;
        endcase
        if (32'(tbl) > WARM_LIMIT) begin
            wait_c = 16'(WARM_LIMIT);
        end else begin
            wait_c = tbl;
        end
    end

    // Register port, status capture and the interrupt level.
    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        stat_d = stat_q;
        rd_d = 16'h0000;
        if (bus_req.we && bus_req.addr == adcw_pkg::OFS_CTRL) begin
            ctrl_d = bus_req.wdata & adcw_pkg::CTRL_WMASK;
        end else if (bus_req.we && bus_req.addr == adcw_pkg::OFS_MASK) begin
            mask_d = bus_req.wdata[4:0];
        end
        if (bus_req.re && bus_req.addr == adcw_pkg::OFS_CTRL) begin
            rd_d = ctrl_q;
        end else if (bus_req.re && bus_req.addr == adcw_pkg::OFS_STAT) begin
            rd_d = {11'h000, stat_q};
            stat_d = adcw_pkg::STAT_RST;
        end else if (bus_req.re && bus_req.addr == adcw_pkg::OFS_MASK) begin
            rd_d = {11'h000, mask_q};
        end else if (bus_req.re && bus_req.addr == adcw_pkg::OFS_CORE) begin
            rd_d = {11'h000, ready_w};
        end
        // An event in the same cycle as the clearing read is kept.
        stat_d = stat_d | evt_w;
        en_d[4] = ctrl_d[adcw_pkg::SHR_EN_BIT];
        en_d[3] = ctrl_d[3];
        en_d[2] = ctrl_d[2];
        en_d[1] = ctrl_d[1];
        en_d[0] = ctrl_d[0];
        irq_d = |(stat_d & mask_d & en_d);
    end

    assign en_w = {ctrl_q[adcw_pkg::SHR_EN_BIT], ctrl_q[3:0]};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= adcw_pkg::CTRL_RST;
            mask_q <= adcw_pkg::MASK_RST;
            stat_q <= adcw_pkg::STAT_RST;
            rd_q <= 16'h0000;
            irq_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
            rd_q <= rd_d;
            irq_q <= irq_d;
        end
    end

    property p_code_write;
        @(posedge mclk) disable iff (!rst_n)
        bus_req.we && bus_req.addr == adcw_pkg::OFS_CTRL
        |=> ctrl_q[11:8] == $past(bus_req.wdata[11:8]);
    endproperty
    a_code_write: assert property (p_code_write)
        else $error("warm-up code not stored");

    property p_unimpl;
        @(posedge mclk) disable iff (!rst_n)
        bus_req.re && bus_req.addr == adcw_pkg::OFS_CTRL
        |=> rd_q[6:4] == 3'h0 && rd_q[15:12] == 4'h0;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented control bits read nonzero");

    property p_len_max;
        @(posedge mclk) disable iff (!rst_n)
        ctrl_q[11:8] == 4'hf && WARM_LIMIT >= 32768 |-> wait_c == 16'h8000;
    endproperty
    a_len_max: assert property (p_len_max)
        else $error("code 1111 does not give 32768 periods");

    property p_len_e;
        @(posedge mclk) disable iff (!rst_n)
        ctrl_q[11:8] == 4'he && WARM_LIMIT >= 16384 |-> wait_c == 16'h4000;
    endproperty
    a_len_e: assert property (p_len_e)
        else $error("code 1110 does not give 16384 periods");

    property p_len_a;
        @(posedge mclk) disable iff (!rst_n)
        ctrl_q[11:8] == 4'ha && WARM_LIMIT >= 1024 |-> wait_c == 16'h0400;
    endproperty
    a_len_a: assert property (p_len_a)
        else $error("code 1010 does not give 1024 periods");

    property p_len_8;
        @(posedge mclk) disable iff (!rst_n)
        ctrl_q[11:8] == 4'h8 && WARM_LIMIT >= 256 |-> wait_c == 16'h0100;
    endproperty
    a_len_8: assert property (p_len_8)
        else $error("code 1000 does not give 256 periods");

    property p_len_5;
        @(posedge mclk) disable iff (!rst_n)
        ctrl_q[11:8] == 4'h5 && WARM_LIMIT >= 32 |-> wait_c == 16'h0020;
    endproperty
    a_len_5: assert property (p_len_5)
        else $error("code 0101 does not give 32 periods");

    property p_len_min;
        @(posedge mclk) disable iff (!rst_n)
        ctrl_q[11:10] == 2'b00 && WARM_LIMIT >= 16 |-> wait_c == 16'h0010;
    endproperty
    a_len_min: assert property (p_len_min)
        else $error("low codes do not give 16 periods");

    property p_shr_irq;
        @(posedge mclk) disable iff (!rst_n)
        evt_w[4] && ctrl_q[7] && mask_q[4] && !bus_req.we |=> irq_q;
    endproperty
    a_shr_irq: assert property (p_shr_irq)
        else $error("shared core ready did not raise the interrupt");

    property p_c3_irq;
        @(posedge mclk) disable iff (!rst_n)
        evt_w[3] && ctrl_q[3] && mask_q[3] && !bus_req.we |=> irq_q;
    endproperty
    a_c3_irq: assert property (p_c3_irq)
        else $error("core 3 ready did not raise the interrupt");

    property p_c2_irq;
        @(posedge mclk) disable iff (!rst_n)
        stat_q[2] && !ctrl_q[2] && !(stat_q[4:3] != 2'b00)
        && !(stat_q[1:0] != 2'b00) && evt_w == 5'h00 && !bus_req.we
        |=> !irq_q;
    endproperty
    a_c2_irq: assert property (p_c2_irq)
        else $error("disabled core 2 event raised the interrupt");

    property p_c1_irq;
        @(posedge mclk) disable iff (!rst_n)
        evt_w[1] && ctrl_q[1] && mask_q[1] && !bus_req.we |=> irq_q;
    endproperty
    a_c1_irq: assert property (p_c1_irq)
        else $error("core 1 ready did not raise the interrupt");

    property p_c0_irq;
        @(posedge mclk) disable iff (!rst_n)
        stat_q[0] && ctrl_q[0] && mask_q[0] |-> irq_q;
    endproperty
    a_c0_irq: assert property (p_c0_irq)
        else $error("core 0 status set but interrupt low");

    property p_irq_quiet;
        @(posedge mclk) disable iff (!rst_n)
        (stat_q & mask_q & en_w) == 5'h00 |-> !irq_q;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("interrupt high with nothing enabled");

endmodule

// ==== design/adcw_warm_cnt.sv ====
// Warm-up timer for one converter core.
// Assumes pwr is already synchronous and wait_cyc is at least one.
module adcw_warm_cnt (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Core side
    input wire logic pwr,
    input wire logic [15:0] wait_cyc,
    output logic ready_q,
    output logic event_q
);

    adcw_pkg::adcw_warm_e state_q;
    adcw_pkg::adcw_warm_e state_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic ready_d;
    logic event_d;
    // Only the checks below read these.
    logic [15:0] el_q;
    logic [15:0] wlat_q;

    // The length is taken when the core powers up; a later change of the
    // code waits for the next power-up, so a running count never jumps.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        event_d = 1'b0;
        case (state_q)
            adcw_pkg::ST_OFF: begin
                if (pwr) begin
                    state_d = adcw_pkg::ST_WARM;
                    cnt_d = wait_cyc - 16'h0001;
                end
            end
            adcw_pkg::ST_WARM: begin
                if (!pwr) begin
                    state_d = adcw_pkg::ST_OFF;
                end else if (cnt_q == 16'h0000) begin
                    state_d = adcw_pkg::ST_RDY;
                    event_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            adcw_pkg::ST_RDY: begin
                if (!pwr) begin
                    state_d = adcw_pkg::ST_OFF;
                end
            end
            default: state_d = adcw_pkg::ST_OFF;
        endcase
        ready_d = (state_d == adcw_pkg::ST_RDY);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= adcw_pkg::ST_OFF;
            cnt_q <= 16'h0000;
            ready_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
            event_q <= event_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            el_q <= 16'h0000;
            wlat_q <= 16'h0000;
        end else begin
            if (state_q == adcw_pkg::ST_WARM) begin
                el_q <= el_q + 16'h0001;
            end else begin
                el_q <= 16'h0000;
            end
            if (state_q == adcw_pkg::ST_OFF && pwr) begin
                wlat_q <= wait_cyc;
            end
        end
    end

    property p_warm_len;
        @(posedge mclk) disable iff (!rst_n)
        $rose(ready_q) |-> $past(el_q) == $past(wlat_q) - 16'h0001;
    endproperty
    a_warm_len: assert property (p_warm_len)
        else $error("core became ready after the wrong warm-up length");

    property p_drop;
        @(posedge mclk) disable iff (!rst_n)
        !pwr |=> !ready_q && !event_q;
    endproperty
    a_drop: assert property (p_drop)
        else $error("core ready while powered down");

    property p_event_once;
        @(posedge mclk) disable iff (!rst_n)
        event_q |-> ready_q ##1 !event_q;
    endproperty
    a_event_once: assert property (p_event_once)
        else $error("ready event not a single pulse with ready");

endmodule

// ==== inc/adcw_pkg.sv ====
// Shared constants and types for the converter core warm-up and ready
// interrupt block.
// Assumes one clock, the core source clock, drives every flip-flop.
package adcw_pkg;

    // Register port geometry.
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    // Four dedicated cores at indices 0 to 3, the shared core at index 4.
    localparam int unsigned NCORE = 5;
    localparam int unsigned SHR_IDX = 4;

    // Register offsets, one 16-bit word each.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STAT = 4'h1;
    localparam logic [3:0] OFS_MASK = 4'h2;
    localparam logic [3:0] OFS_CORE = 4'h3;

    // Control word fields.
    localparam int unsigned CODE_LSB = 8;
    localparam int unsigned CODE_MSB = 11;
    localparam int unsigned SHR_EN_BIT = 7;
    localparam logic [15:0] CTRL_WMASK = 16'h0f8f;

    // Reset values.
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [4:0] MASK_RST = 5'h1f;
    localparam logic [4:0] STAT_RST = 5'h00;

    // Warm-up lengths in core source clock periods.
    localparam logic [15:0] WARM_CYC_MIN = 16'h0010;
    localparam int unsigned WARM_CYC_MAX = 32768;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic we;
        logic re;
    } adcw_bus_req_s;

    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_WARM = 3'b010,
        ST_RDY = 3'b100
    } adcw_warm_e;

endpackage
